// file: design/pbt_mean.sv
`timescale 1ns/100ps
`default_nettype none
module pbt_mean
	import pbt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic sample_valid,
	input wire logic [PBT_SAMPLE_W-1:0] sample,
	input wire logic freeze,
	input wire logic [PBT_CTRL_LEN_W-1:0] len_log2,
	output logic [PBT_SAMPLE_W-1:0] mean
);
	logic [PBT_SAMPLE_W-1:0] hist_reg [PBT_MAX_LEN];
	logic [PBT_ACC_W-1:0] psum [PBT_MAX_LEN+1];
	logic [PBT_CTRL_LEN_W-1:0] len_c;
	logic take;

	assign take = sample_valid && !freeze;
	assign len_c = (len_log2 > 3'(PBT_MAX_LOG2)) ? 3'(PBT_MAX_LOG2) : len_log2;
	// The window is summed afresh each cycle, so a new length takes effect without drift.
	assign psum[0] = '0;
	assign mean = PBT_SAMPLE_W'(psum[PBT_MAX_LEN] >> len_c);

	genvar i;
	generate
		for (i = 0; i < PBT_MAX_LEN; i++) begin : g_hist
			assign psum[i + 1] = psum[i] + ((32'(i) < (32'd1 << len_c)) ?
				PBT_ACC_W'(hist_reg[i]) : PBT_ACC_W'(0));
			always_ff @(posedge mclk) begin
				if (rst) begin
					hist_reg[i] <= '0;
				end else if (take) begin
					hist_reg[i] <= (i == 0) ? sample : hist_reg[(i == 0) ? 0 : i - 1];
				end
			end
		end
	endgenerate
endmodule // pbt_mean
`default_nettype wire

// file: design/pbt_pkg.sv
package pbt_pkg;
	// Sample width and baseline averaging options.
	localparam int PBT_SAMPLE_W = 12;
	localparam int PBT_MAX_LOG2 = 5;
	localparam int PBT_MAX_LEN = 32;
	localparam int PBT_ACC_W = PBT_SAMPLE_W + PBT_MAX_LOG2;
	localparam int PBT_CNT_W = 16;

	// Register offsets (byte addresses).
	localparam logic [7:0] PBT_ADDR_CTRL = 8'h00;
	localparam logic [7:0] PBT_ADDR_FIXED = 8'h04;
	localparam logic [7:0] PBT_ADDR_THRESH = 8'h08;
	localparam logic [7:0] PBT_ADDR_HOLDOFF = 8'h0c;
	localparam logic [7:0] PBT_ADDR_STATUS = 8'h10;
	localparam logic [7:0] PBT_ADDR_BASE = 8'h14;

	// Control field positions.
	localparam int PBT_CTRL_FIXED_BIT = 0;
	localparam int PBT_CTRL_POL_BIT = 1;
	localparam int PBT_CTRL_SWTRG_BIT = 2;
	localparam int PBT_CTRL_LEN_LSB = 4;
	localparam int PBT_CTRL_LEN_W = 3;

	// Reset values.
	localparam logic [31:0] PBT_CTRL_RST = 32'h0000_0052;
	localparam logic [PBT_SAMPLE_W-1:0] PBT_FIXED_RST = 12'h000;
	localparam logic [PBT_SAMPLE_W-1:0] PBT_THRESH_RST = 12'h064;
	localparam logic [PBT_CNT_W-1:0] PBT_HOLDOFF_RST = 16'h0000;

	typedef enum logic [1:0] {
		PBT_TRACK = 2'b00,
		PBT_GATED = 2'b01,
		PBT_HOLD = 2'b10
	} pbt_state_type;
endpackage : pbt_pkg

// file: design/pbt_top.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Averaging mode baseline is the running mean of recent samples.
// - Length field selects window of 1 to 32 samples, power of two.
// - Fixed mode uses the programmed absolute baseline in ADC counts.
// - Trigger and charge zero reference is the current baseline.
// - Averaging baseline freezes while the gate is open.
// - Freeze extends through the programmed hold-off count after the gate closes; triggers are not held off.
// - Fixed baseline stays constant regardless of gates or triggers.
// - Threshold is unsigned LSB magnitude from baseline.
// - With software trigger off, threshold crossings self-trigger.
module pbt_top
	import pbt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sample_valid,
	input wire logic [PBT_SAMPLE_W-1:0] sample,
	input wire logic gate_open,
	output logic [PBT_SAMPLE_W-1:0] baseline,
	output logic [PBT_SAMPLE_W:0] signal_net,
	output logic self_trigger,
	output logic over_threshold,
	output logic baseline_frozen
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] ctrl_reg;
	logic [PBT_SAMPLE_W-1:0] fixed_reg;
	logic [PBT_SAMPLE_W-1:0] thresh_reg;
	logic [PBT_CNT_W-1:0] holdoff_reg;
	logic [PBT_CNT_W-1:0] hold_cnt_reg;
	logic [PBT_CNT_W-1:0] hold_cnt_next;
	pbt_state_type state_reg;
	pbt_state_type state_next;
	logic over_reg;
	logic [31:0] rd_data;
	logic req;
	logic wr;
	logic [31:0] wmask;
	logic fixed_mode;
	logic pos_pol;
	logic sw_trg;
	logic freeze;
	logic [PBT_SAMPLE_W-1:0] mean;
	logic [PBT_SAMPLE_W-1:0] base_sel;
	logic [PBT_SAMPLE_W:0] depart;
	logic over_now;
	logic trig_now;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign rd_data = (wb_adr_i[7:0] == PBT_ADDR_CTRL) ? ctrl_reg :
		(wb_adr_i[7:0] == PBT_ADDR_FIXED) ? 32'(fixed_reg) :
		(wb_adr_i[7:0] == PBT_ADDR_THRESH) ? 32'(thresh_reg) :
		(wb_adr_i[7:0] == PBT_ADDR_HOLDOFF) ? 32'(holdoff_reg) :
		(wb_adr_i[7:0] == PBT_ADDR_STATUS) ?
			32'({over_reg, baseline_frozen, 2'(state_reg)}) :
		(wb_adr_i[7:0] == PBT_ADDR_BASE) ? 32'(baseline) : 32'h0000_0000;

	always_ff @(posedge mclk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_data : 32'h0000_0000;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_reg <= PBT_CTRL_RST;
			fixed_reg <= PBT_FIXED_RST;
			thresh_reg <= PBT_THRESH_RST;
			holdoff_reg <= PBT_HOLDOFF_RST;
		end else if (wr) begin
			case (wb_adr_i[7:0])
				PBT_ADDR_CTRL: ctrl_reg <= (ctrl_reg & ~wmask) | (wb_dat_i & wmask & 32'h0000_0077);
				PBT_ADDR_FIXED: fixed_reg <= PBT_SAMPLE_W'((32'(fixed_reg) & ~wmask) | (wb_dat_i & wmask));
				PBT_ADDR_THRESH: thresh_reg <= PBT_SAMPLE_W'((32'(thresh_reg) & ~wmask) | (wb_dat_i & wmask));
				PBT_ADDR_HOLDOFF: holdoff_reg <= PBT_CNT_W'((32'(holdoff_reg) & ~wmask) | (wb_dat_i & wmask));
				default: ;
			endcase
		end
	end

	assign fixed_mode = ctrl_reg[PBT_CTRL_FIXED_BIT];
	assign pos_pol = ctrl_reg[PBT_CTRL_POL_BIT];
	assign sw_trg = ctrl_reg[PBT_CTRL_SWTRG_BIT];

	// ----------------------------------------
	// Freeze sequencing
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		hold_cnt_next = hold_cnt_reg;
		case (state_reg)
			PBT_TRACK: begin
				if (gate_open) begin
					state_next = PBT_GATED;
				end
			end
			PBT_GATED: begin
				if (!gate_open) begin
					state_next = (holdoff_reg == '0) ? PBT_TRACK : PBT_HOLD;
					hold_cnt_next = holdoff_reg;
				end
			end
			PBT_HOLD: begin
				if (gate_open) begin
					state_next = PBT_GATED;
				end else if (hold_cnt_reg <= 16'h0001) begin
					state_next = PBT_TRACK;
					hold_cnt_next = '0;
				end else begin
					hold_cnt_next = hold_cnt_reg - 16'h0001;
				end
			end
			default: state_next = PBT_TRACK;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= PBT_TRACK;
			hold_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			hold_cnt_reg <= hold_cnt_next;
		end
	end

	assign freeze = gate_open || (state_reg != PBT_TRACK);

	pbt_mean u_mean (
		.mclk(mclk),
		.rst(rst),
		.sample_valid(sample_valid),
		.sample(sample),
		.freeze(freeze),
		.len_log2(ctrl_reg[PBT_CTRL_LEN_LSB +: PBT_CTRL_LEN_W]),
		.mean(mean)
	);

	// ----------------------------------------
	// Baseline and trigger
	// ----------------------------------------
	// fixed value ignores gate
	assign base_sel = fixed_mode ? fixed_reg : mean;
	assign depart = pos_pol ? ({1'b0, sample} - {1'b0, base_sel}) :
		({1'b0, base_sel} - {1'b0, sample});
	assign over_now = !depart[PBT_SAMPLE_W] && (depart[PBT_SAMPLE_W-1:0] >= thresh_reg);
	assign trig_now = !sw_trg && sample_valid && over_now && !over_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			baseline <= '0;
			signal_net <= '0;
			self_trigger <= 1'b0;
			over_threshold <= 1'b0;
			over_reg <= 1'b0;
			baseline_frozen <= 1'b0;
		end else begin
			baseline <= base_sel;
			self_trigger <= trig_now;
			// Net signal and level follow valid samples only, like the crossing detector.
			if (sample_valid) begin
				signal_net <= depart;
				over_threshold <= over_now;
				over_reg <= over_now;
			end
			baseline_frozen <= fixed_mode || freeze;
		end
	end
endmodule // pbt_top
`default_nettype wire

// file: verif/pbt_adc_model.sv
`timescale 1ns/100ps
`default_nettype none
module pbt_adc_model
	import pbt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [PBT_SAMPLE_W-1:0] level,
	output logic sample_valid,
	output logic [PBT_SAMPLE_W-1:0] sample
);
	// The converter delivers one sample per clock once out of reset.
	always_ff @(posedge mclk) begin
		sample_valid <= !rst;
		sample <= level;
	end
endmodule // pbt_adc_model
`default_nettype wire

// file: verif/pbt_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
module pbt_top_chk
	import pbt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic gate_open,
	input wire logic [PBT_SAMPLE_W-1:0] baseline,
	input wire logic [PBT_SAMPLE_W:0] signal_net,
	input wire logic self_trigger,
	input wire logic over_threshold,
	input wire logic baseline_frozen
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence frozen_s;
		baseline_frozen [*4];
	endsequence
	a_ack_after_req: assert property (req_s |=> wb_ack_o)
		else $error("request not acknowledged");
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data not zero outside ack");
	a_trig_one_pulse: assert property (self_trigger |=> !self_trigger)
		else $error("trigger longer than one cycle");
	a_trig_on_rise: assert property (self_trigger |-> over_threshold && !$past(over_threshold))
		else $error("trigger without rising crossing");
	a_over_right_side: assert property (over_threshold |-> !signal_net[PBT_SAMPLE_W])
		else $error("over threshold on the wrong side");
	a_gate_freezes: assert property (gate_open |=> baseline_frozen)
		else $error("baseline not frozen by gate");
	a_frozen_stable: assert property (frozen_s |-> $stable(baseline))
		else $error("baseline moved while frozen");
endmodule // pbt_top_chk
bind pbt_top pbt_top_chk pbt_top_chk_i (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .gate_open(gate_open),
	.baseline(baseline), .signal_net(signal_net), .self_trigger(self_trigger),
	.over_threshold(over_threshold), .baseline_frozen(baseline_frozen));
`default_nettype wire

// file: verif/tb_pbt_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pbt_top;
	import pbt_pkg::*;
	logic mclk = 0, rst = 1, we = 0, cyc = 0, stb = 0, gate = 0, ack, vld, trg, ovr, frz;
	logic [31:0] adr = 0, dat = 0, dato, q;
	logic [11:0] lvl = 12'h07d0, smp, base;
	logic [12:0] net;
	int fails = 0, n_compared = 0, c;
	logic [7:0] tc [6] = '{8'h33, 8'h33, 8'h33, 8'h31, 8'h31, 8'h37};
	logic [11:0] tv [6] = '{12'h080f, 12'h0810, 12'h07f0, 12'h07f0, 12'h0810, 12'h0810};
	int tp [6] = '{0, 1, 0, 1, 0, 0};
	logic ts [6] = '{0, 0, 1, 0, 1, 0};
	always #4 mclk = ~mclk;
	pbt_adc_model pbt_adc_model_i (.mclk(mclk), .rst(rst), .level(lvl), .sample_valid(vld),
		.sample(smp));
	pbt_top pbt_top_i (.mclk(mclk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dato),
		.wb_ack_o(ack), .sample_valid(vld), .sample(smp), .gate_open(gate), .baseline(base),
		.signal_net(net), .self_trigger(trg), .over_threshold(ovr), .baseline_frozen(frz));
	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, 24'h0000_00, a, d};
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dato;
		{cyc, stb, we} <= 3'b000;
		if (n >= 20) begin
			fails++;
			stop_test();
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	initial begin
		wt(4);
		rst <= 0;
		bus(8'h00, 0, 0); chk(q, 32'h0000_0052);
		bus(8'h08, 0, 0); chk(q, 32'h0000_0064);
		bus(8'h20, 0, 0); chk(q, 32'h0000_0000);
		wt(40); chk(base, 12'h07d0);
		lvl <= 12'h0820; wt(12); chk(base > 12'h07d0 && base < 12'h0820, 1);
		bus(8'h00, 1, 32'h0000_0032); wt(40);
		lvl <= 12'h07d0; wt(12); chk(base, 12'h07d0);
		bus(8'h0c, 1, 32'h0000_0014);
		gate <= 1; wt(3); lvl <= 12'h0900; wt(30); chk(base, 12'h07d0);
		gate <= 0; wt(10); chk(base, 12'h07d0); chk(frz, 1);
		wt(40); chk(base, 12'h0900);
		bus(8'h04, 1, 32'h0000_0800);
		bus(8'h00, 1, 32'h0000_0033);
		wt(4); chk(base, 12'h0800);
		gate <= 1; wt(5); gate <= 0; wt(30); chk(base, 12'h0800);
		bus(8'h08, 1, 32'h0000_0010);
		lvl <= 12'h0800;
		for (int i = 0; i < 6; i++) begin
			bus(8'h00, 1, {24'h0000_00, tc[i]}); wt(6);
			c = 0;
			lvl <= tv[i];
			repeat (6) begin
				@(posedge mclk);
				c += (trg === 1'b1);
			end
			chk(c, tp[i]);
			chk(ovr, tp[i] || tc[i][2]);
			chk(net[12], ts[i]);
			if (!ts[i] && tc[i][1]) chk(net, {1'b0, tv[i] - 12'h0800});
			lvl <= 12'h0800;
		end
		stop_test();
	end
endmodule // tb_pbt_top
`default_nettype wire
